// ==== verilog/adc_ctrl.sv ====
// Purpose: APB register file and control of a 10-bit converter core
// Assumes: Zero-wait APB slave; core ready and result are asynchronous levels
// Notes: Result word must be stable while core ready is high
// Contract
// - Bit 15 zeroes regulator; bit 14 enables it
// - Chop takes two opposite-sign samples
// - Mute samples at mid-scale
// - Bit 11 picks differential or single-ended
// - Sign bit inverts input and output polarity
// - Single-ended codes pick pins or internal nodes
// - Differential code zero pins 0/1, else 2/3
// - Bit 5 gates done interrupt out
// - Done flag holds until clear write
// - Bit 3 picks conversion clock
// - Start bit self-clears and sets done flag
// - Enable low holds converter in reset
// - Second bit 3 adds constant load
// - Second bit 2 adds dynamic load
// - Second bit 1 enables triple attenuator
// - Delay sequencing bit never hardware-cleared
// - Result register shows last 10-bit value
// - Clear write drops flag unless a completion lands in the same cycle; reads zero
`default_nettype none

`include "adc_ctrl_defs.svh"

module adc_ctrl (
  input wire logic pclk, // APB clock
  input wire logic presetn, // Async reset, low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [31:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic core_ready, // Core sample ready
  input wire logic [9:0] core_result, // Core sample value
  output logic sample_req, // Sample request to core
  output logic sample_sign, // Polarity of sample
  output logic converter_reset_n, // Core reset, low
  output logic regulator_force_zero, // Regulator output to zero
  output logic regulator_on, // Regulator on
  output logic chop_option, // Chop mode
  output logic midscale_sample, // Mid-scale sampling
  output logic single_ended_select, // Single-ended inputs
  output logic [3:0] channel_select, // Channel code
  output logic [3:0] input_route, // Positive input source
  output logic channel_reserved, // Reserved code selected
  output logic conversion_clock_choice, // Digital clock chosen
  output logic constant_load_current, // Constant load on
  output logic dynamic_load_current, // Dynamic load on
  output logic triple_attenuator, // Triple attenuator on
  output logic delay_sequencing_enable, // Delay sequencing on
  output logic done_irq // Interrupt to controller
);
  import adc_ctrl_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [15:0] ctrl;
    logic [3:0] ctrl2;
    logic start;
    logic flag;
    logic [9:0] result;
    logic [31:0] rdata;
    logic err;
  } regs_t;

  regs_t regs_r;
  regs_t regs_nxt;

  logic rdy_s;
  logic seq_done;
  logic [9:0] seq_result;
  logic setup;
  logic access;
  logic go;
  logic clear_wr;
  logic ctrl_wr;
  reg_sel_t sel_now;

  function automatic reg_sel_t decode(input logic [31:0] a);
    if (a == byte_addr(`CTRL_IDX)) begin
      return SEL_CTRL;
    end else if (a == byte_addr(`CTRL2_IDX)) begin
      return SEL_CTRL2;
    end else if (a == byte_addr(`CLEAR_IDX)) begin
      return SEL_CLEAR;
    end else if (a == byte_addr(`RESULT_IDX)) begin
      return SEL_RESULT;
    end else begin
      return SEL_NONE;
    end
  endfunction

  // ****************************************
  // Core side
  // ****************************************
  adc_sync2 #(.W(1)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(core_ready),
    .q(rdy_s)
  );

  adc_conv_seq u_seq (
    .clk(pclk),
    .rst_n(presetn),
    .en(regs_r.ctrl[`B_EN]),
    .go(go),
    .chop(regs_r.ctrl[`B_CHOP]),
    .sign_inv(regs_r.ctrl[`B_SIGN]),
    .rdy(rdy_s),
    .data(core_result),
    .req(sample_req),
    .sign(sample_sign),
    .done(seq_done),
    .result(seq_result)
  );

  // ****************************************
  // Register file
  // ****************************************
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign sel_now = decode(paddr);
  assign ctrl_wr = access && pwrite && (sel_now == SEL_CTRL);
  assign clear_wr = access && pwrite && (sel_now == SEL_CLEAR);
  // Start needs enable in the same write
  assign go = ctrl_wr && pwdata[`B_START] && pwdata[`B_EN] && !regs_r.start;

  always_comb begin
    regs_nxt = regs_r;
    if (setup) begin
      regs_nxt.err = (sel_now == SEL_NONE);
      case (sel_now)
        SEL_CTRL: regs_nxt.rdata = {16'h0000, regs_r.ctrl[15:5], regs_r.flag,
                                    regs_r.ctrl[`B_CLK_CHOICE], 1'b0, regs_r.start,
                                    regs_r.ctrl[`B_EN]};
        SEL_CTRL2: regs_nxt.rdata = {28'h0000000, regs_r.ctrl2};
        SEL_RESULT: regs_nxt.rdata = {22'h000000, regs_r.result};
        default: regs_nxt.rdata = 32'h0000_0000;
      endcase
    end
    if (ctrl_wr) begin
      regs_nxt.ctrl = {pwdata[15:5], 1'b0, pwdata[`B_CLK_CHOICE], 2'b00, pwdata[`B_EN]};
    end
    if (access && pwrite && (sel_now == SEL_CTRL2)) begin
      regs_nxt.ctrl2 = pwdata[3:0];
    end
    if (go) begin
      regs_nxt.start = 1'b1;
    end
    if (clear_wr) begin
      regs_nxt.flag = 1'b0;
    end
    if (seq_done) begin
      // Completion wins over a clear in the same cycle
      regs_nxt.start = 1'b0;
      regs_nxt.flag = 1'b1;
      regs_nxt.result = seq_result;
    end
    if (!regs_nxt.ctrl[`B_EN]) begin
      regs_nxt.start = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regs_r.ctrl <= `CTRL_RST;
      regs_r.ctrl2 <= `CTRL2_RST;
      regs_r.start <= 1'b0;
      regs_r.flag <= 1'b0;
      regs_r.result <= `RESULT_RST;
      regs_r.rdata <= 32'h0000_0000;
      regs_r.err <= 1'b0;
    end else begin
      regs_r <= regs_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata = regs_r.rdata;
  assign pready = 1'b1;
  assign pslverr = access && regs_r.err;

  assign regulator_force_zero = regs_r.ctrl[`B_FORCE_ZERO];
  assign regulator_on = regs_r.ctrl[`B_REG_ON];
  assign chop_option = regs_r.ctrl[`B_CHOP];
  assign midscale_sample = regs_r.ctrl[`B_MUTE];
  assign single_ended_select = regs_r.ctrl[`B_SE];
  assign channel_select = regs_r.ctrl[`F_SEL_HI:`F_SEL_LO];
  assign conversion_clock_choice = regs_r.ctrl[`B_CLK_CHOICE];
  assign converter_reset_n = regs_r.ctrl[`B_EN];
  assign constant_load_current = regs_r.ctrl2[`B2_CONST_LOAD];
  assign dynamic_load_current = regs_r.ctrl2[`B2_DYN_LOAD];
  assign triple_attenuator = regs_r.ctrl2[`B2_ATTEN];
  assign delay_sequencing_enable = regs_r.ctrl2[`B2_DELAY_SEQ];
  assign done_irq = regs_r.flag && regs_r.ctrl[`B_UNMASK];

  // Positive input: pin or node code, or pair base pin
  always_comb begin
    if (single_ended_select) begin
      input_route = channel_select;
      channel_reserved = channel_select > `LAST_SE_CODE;
    end else begin
      input_route = (channel_select == 4'h0) ? 4'h0 : `DIFF_PAIR_HI;
      channel_reserved = 1'b0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  start_needs_en_a: assert property (ctrl_wr && !pwdata[`B_EN] |=> !regs_r.start)
    else $error("start accepted while disabled");
  start_taken_a: assert property (go |=> regs_r.start && sample_req)
    else $error("start write not taken");
  done_sets_flag_a: assert property (seq_done |=> !regs_r.start && regs_r.flag)
    else $error("completion did not clear start and set flag");
  flag_holds_a: assert property (regs_r.flag && !clear_wr |=> regs_r.flag)
    else $error("done flag dropped without clear");
  clear_drops_a: assert property (clear_wr && !seq_done |=> !regs_r.flag)
    else $error("clear write left flag set");
  irq_follows_a: assert property (seq_done && regs_r.ctrl[`B_UNMASK] && !ctrl_wr
                                  |=> done_irq)
    else $error("unmasked completion raised no interrupt");
  irq_masked_a: assert property (!regs_r.ctrl[`B_UNMASK] |-> !done_irq)
    else $error("masked interrupt forwarded");
  disable_idle_a: assert property (!regs_r.ctrl[`B_EN] |=> !sample_req)
    else $error("request while converter disabled");
  result_load_a: assert property (seq_done |=> regs_r.result == $past(seq_result))
    else $error("result not loaded on completion");
  diff_pair_a: assert property (!single_ended_select && channel_select != 4'h0
                                |-> input_route == `DIFF_PAIR_HI)
    else $error("differential pair misrouted");
  clear_reads_zero_a: assert property (setup && sel_now == SEL_CLEAR |=> prdata == 32'h0)
    else $error("clear register read nonzero");

  single_conv_c: cover property (go ##[1:40] seq_done && !chop_option);
  chop_conv_c: cover property (go ##[1:80] seq_done && chop_option);
  clear_race_c: cover property (seq_done && clear_wr);
  bad_addr_c: cover property (pslverr);
endmodule

`default_nettype wire

// ==== verilog/adc_ctrl_defs.svh ====
// Purpose: Offsets, field positions and reset values of the converter control block
// Assumes: Printed offsets are register indices; byte address is four times the index
// Notes: Definitions only
`ifndef ADC_CTRL_DEFS_SVH
`define ADC_CTRL_DEFS_SVH

`define CTRL_IDX 32'h5000_1500
`define CTRL2_IDX 32'h5000_1502
`define CLEAR_IDX 32'h5000_1508
`define RESULT_IDX 32'h5000_150A

`define CTRL_RST 16'h0000
`define CTRL2_RST 4'h0
`define RESULT_RST 10'h000

`define B_FORCE_ZERO 15
`define B_REG_ON 14
`define B_CHOP 13
`define B_MUTE 12
`define B_SE 11
`define B_SIGN 10
`define F_SEL_HI 9
`define F_SEL_LO 6
`define B_UNMASK 5
`define B_FLAG 4
`define B_CLK_CHOICE 3
`define B_START 1
`define B_EN 0

`define B2_CONST_LOAD 3
`define B2_DYN_LOAD 2
`define B2_ATTEN 1
`define B2_DELAY_SEQ 0

`define LAST_SE_CODE 4'h9
`define DIFF_PAIR_HI 4'h2

`endif

// ==== verilog/adc_ctrl_pkg.sv ====
// Purpose: Types shared by the converter control block
// Assumes: Nothing beyond the defs header
// Notes: Constants live in the defs header
`default_nettype none

package adc_ctrl_pkg;

  typedef enum logic [2:0] {SEL_NONE, SEL_CTRL, SEL_CTRL2, SEL_CLEAR, SEL_RESULT} reg_sel_t;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_REQ, SEQ_REL} seq_state_t;

  typedef struct packed {
    seq_state_t state;
    logic second;
    logic more;
    logic done;
    logic [9:0] first;
    logic [9:0] res;
  } seq_t;

  function automatic logic [31:0] byte_addr(input logic [31:0] idx);
    return {idx[29:0], 2'b00};
  endfunction

endpackage

`default_nettype wire

// ==== verilog/adc_sync2.sv ====
// Purpose: Two-flop synchroniser for levels from the converter core
// Assumes: Input is a level that holds for several clocks
// Notes: First stage feeds only the second stage
`default_nettype none

module adc_sync2 #(
  parameter int W = 1
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Async reset, low
  input wire logic [W-1:0] d, // Asynchronous level
  output logic [W-1:0] q // Synchronised level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } st_t;

  st_t st_r;
  st_t st_nxt;

  always_comb begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;
endmodule

`default_nettype wire

// ==== verilog/adc_conv_seq.sv ====
// Purpose: Sequences one conversion, or a chopped pair, with the converter core
// Assumes: Core raises ready with stable data per request, drops it after request falls
// Notes: Chopped pair result is the mean of both samples
`default_nettype none

module adc_conv_seq
  import adc_ctrl_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst_n, // Async reset, low
  input wire logic en, // Converter enabled
  input wire logic go, // Start pulse
  input wire logic chop, // Take opposite-sign pair
  input wire logic sign_inv, // Base sign
  input wire logic rdy, // Synchronised core ready
  input wire logic [9:0] data, // Core sample
  output logic req, // Sample request to core
  output logic sign, // Sign of current sample
  output logic done, // One-cycle completion
  output logic [9:0] result // Final value
);
  seq_t st_r;
  seq_t st_nxt;
  logic [10:0] sum;

  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    sum = {1'b0, st_r.first} + {1'b0, data};
    case (st_r.state)
      SEQ_IDLE: begin
        if (go) begin
          st_nxt.state = SEQ_REQ;
          st_nxt.second = 1'b0;
        end
      end
      SEQ_REQ: begin
        if (rdy) begin
          st_nxt.state = SEQ_REL;
          if (chop && !st_r.second) begin
            // First half of chopped pair
            st_nxt.first = data;
            st_nxt.more = 1'b1;
          end else begin
            // One completion per chopped pair
            st_nxt.res = chop ? sum[10:1] : data;
            st_nxt.more = 1'b0;
            st_nxt.done = 1'b1;
          end
        end
      end
      SEQ_REL: begin
        if (!rdy) begin
          st_nxt.state = st_r.more ? SEQ_REQ : SEQ_IDLE;
          st_nxt.second = st_r.more;
          st_nxt.more = 1'b0;
        end
      end
      default: st_nxt.state = SEQ_IDLE;
    endcase
    if (!en) begin
      // Disabled core is held idle
      st_nxt.state = SEQ_IDLE;
      st_nxt.more = 1'b0;
      st_nxt.done = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign req = (st_r.state == SEQ_REQ);
  assign sign = sign_inv ^ st_r.second;
  assign done = st_r.done;
  assign result = st_r.res;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chop_flip_sign_a: assert property (en && req && st_r.second |-> sign != sign_inv)
    else $error("second chop sample keeps base sign");
  chop_single_done_a: assert property (req && rdy && chop && !st_r.second && en |=> !done)
    else $error("chop pair completed after one sample");
endmodule

`default_nettype wire

// ==== verification/adc_core_model.sv ====
// Purpose: Behavioural converter core answering sample requests
// Assumes: Value picked by polarity; latency set by the bench
// Notes: Result word toggles every clock while request is low and core is out of reset
`default_nettype none

module adc_core_model (
  input wire logic pclk, // System clock
  input wire logic sample_req, // Request from control
  input wire logic sample_sign, // Polarity of sample
  input wire logic converter_reset_n, // Core reset, low
  input wire logic [7:0] lat, // Cycles before ready
  input wire logic [9:0] val_pos, // Value at plain sign
  input wire logic [9:0] val_neg, // Value at inverted sign
  output logic core_ready, // Sample valid
  output logic [9:0] core_result // Sample value
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_r;

  // ********************
  // Sample answer
  // ********************
  always @(posedge pclk) begin
    if (!converter_reset_n) begin
      cnt_r <= 8'h00;
      core_ready <= 1'b0;
      core_result <= 10'h155;
    end else if (!sample_req) begin
      cnt_r <= 8'h00;
      core_ready <= 1'b0;
      core_result <= ~core_result;
    end else if (cnt_r < lat) begin
      cnt_r <= cnt_r + 8'h01;
    end else begin
      core_ready <= 1'b1;
      core_result <= sample_sign ? val_neg : val_pos;
    end
  end
endmodule

`default_nettype wire

// ==== verification/adc_control_logic_tb.sv ====
// Purpose: Self-checking bench for the converter control block
// Assumes: Zero-wait APB slave; core model on the far side
// Notes: Each scenario is its own task
`default_nettype none

`include "adc_ctrl_defs.svh"

module adc_control_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] A_CTRL = `CTRL_IDX << 2;
  localparam logic [31:0] A_CTRL2 = `CTRL2_IDX << 2;
  localparam logic [31:0] A_CLR = `CLEAR_IDX << 2;
  localparam logic [31:0] A_RES = `RESULT_IDX << 2;
  localparam logic [31:0] A_BAD = (`CTRL_IDX + 32'h1) << 2;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q, core_ready;
  logic req_d = 1'b0;
  logic [31:0] paddr, pwdata, prdata, rd_q;
  logic [9:0] core_result, val_pos, val_neg;
  logic [7:0] lat;
  logic [3:0] channel_select, input_route;
  logic [1:0] sign_log = 2'b00;
  logic sample_req, sample_sign, converter_reset_n, regulator_force_zero, regulator_on;
  logic chop_option, midscale_sample, single_ended_select, channel_reserved;
  logic conversion_clock_choice, constant_load_current, dynamic_load_current;
  logic triple_attenuator, delay_sequencing_enable, done_irq;
  int fail_count, tests_run;
  int n_req = 0;

  adc_ctrl u_adc_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .core_ready, .core_result, .sample_req, .sample_sign,
    .converter_reset_n, .regulator_force_zero, .regulator_on, .chop_option,
    .midscale_sample, .single_ended_select, .channel_select, .input_route,
    .channel_reserved, .conversion_clock_choice, .constant_load_current,
    .dynamic_load_current, .triple_attenuator, .delay_sequencing_enable, .done_irq);

  adc_core_model u_adc_core_model (.pclk, .sample_req, .sample_sign, .converter_reset_n,
    .lat, .val_pos, .val_neg, .core_ready, .core_result);

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Counts request starts and logs their polarity
  always @(posedge pclk) begin
    req_d <= sample_req;
    if (sample_req && !req_d) begin
      n_req <= n_req + 1;
      sign_log <= {sign_log[0], sample_sign};
    end
  end

  // ********************
  // Tasks
  // ********************
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, seen);
      fail_count++;
    end
  endtask

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail_count++;
      end_of_test();
    end
    #1;
  endtask

  task automatic rchk(input string what, input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, rd_q, exp);
  endtask

  task automatic wait_flag();
    int n;
    n = 0;
    do begin
      apb(1'b0, A_CTRL, 32'h0);
      n++;
    end while (rd_q[4] !== 1'b1 && n < 100);
    if (rd_q[4] !== 1'b1) begin
      fail_count++;
      end_of_test();
    end
  endtask

  // ********************
  // Scenarios
  // ********************
  task automatic t_reset();
    rchk("ctrl rst", A_CTRL, 32'h0);
    rchk("ctrl2 rst", A_CTRL2, 32'h0);
    apb(1'b1, A_RES, 32'h3FF);
    rchk("result ro", A_RES, 32'h0);
    apb(1'b1, A_BAD, 32'hFFFF);
    chk("bad err", {31'h0, err_q}, 32'h1);
    rchk("ctrl kept", A_CTRL, 32'h0);
  endtask

  task automatic t_static();
    apb(1'b1, A_CTRL, 32'hFFFC);
    chk("ctrl outs", {26'h0, regulator_force_zero, regulator_on, chop_option, midscale_sample,
      single_ended_select, conversion_clock_choice}, 32'h3F);
    chk("chan", {28'h0, channel_select}, 32'hF);
    chk("irq none", {31'h0, done_irq}, 32'h0);
    chk("core rst", {31'h0, converter_reset_n}, 32'h0);
    rchk("ctrl rd", A_CTRL, 32'hFFE8);
    apb(1'b1, A_CTRL2, 32'hFFFFFFFF);
    chk("ctrl2 outs", {28'h0, constant_load_current, dynamic_load_current, triple_attenuator,
      delay_sequencing_enable}, 32'hF);
    rchk("ctrl2 rd", A_CTRL2, 32'hF);
    apb(1'b1, A_CTRL2, 32'hE);
    chk("delay off", {31'h0, delay_sequencing_enable}, 32'h0);
    apb(1'b1, A_CTRL, 32'h0);
    chk("reg off", {30'h0, regulator_force_zero, regulator_on}, 32'h0);
  endtask

  task automatic t_route();
    logic [3:0] er;
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 16; c++) begin
        apb(1'b1, A_CTRL, 32'((s << 11) | (c << 6)));
        er = (s == 1) ? c[3:0] : ((c == 0) ? 4'h0 : 4'h2);
        chk("route", {28'h0, input_route}, {28'h0, er});
        chk("rsvd", {31'h0, channel_reserved}, {31'h0, s == 1 && c > 9});
      end
    end
  endtask

  task automatic t_disabled();
    apb(1'b1, A_CTRL, 32'h22);
    rchk("no start", A_CTRL, 32'h20);
    chk("no req", {31'h0, sample_req}, 32'h0);
  endtask

  task automatic t_convert();
    lat = 8'd20;
    apb(1'b1, A_CTRL, 32'h961);
    chk("core on", {31'h0, converter_reset_n}, 32'h1);
    apb(1'b1, A_CTRL, 32'h963);
    rchk("busy", A_CTRL, 32'h963);
    chk("req", {31'h0, sample_req}, 32'h1);
    wait_flag();
    chk("ctrl done", rd_q, 32'h971);
    chk("irq on", {31'h0, done_irq}, 32'h1);
    rchk("result", A_RES, {22'h0, val_pos});
    apb(1'b1, A_CTRL, 32'h941);
    chk("irq mask", {31'h0, done_irq}, 32'h0);
    rchk("flag held", A_CTRL, 32'h951);
    apb(1'b1, A_CLR, 32'hA5);
    rchk("flag clr", A_CTRL, 32'h941);
    rchk("clr rd", A_CLR, 32'h0);
    apb(1'b1, A_CTRL, 32'hD43);
    wait_flag();
    chk("irq masked", {31'h0, done_irq}, 32'h0);
    rchk("inv result", A_RES, {22'h0, val_neg});
    apb(1'b1, A_CLR, 32'h0);
  endtask

  task automatic t_chop();
    int n0;
    lat = 8'd5;
    val_pos = 10'h100;
    val_neg = 10'h301;
    apb(1'b1, A_CTRL, 32'h2001);
    n0 = n_req;
    apb(1'b1, A_CTRL, 32'h2003);
    wait_flag();
    chk("pair", n_req - n0, 32'd2);
    chk("signs", {30'h0, sign_log}, 32'h1);
    rchk("mean", A_RES, 32'h200);
    apb(1'b1, A_CLR, 32'h1);
  endtask

  task automatic t_abort();
    lat = 8'd60;
    apb(1'b1, A_CTRL, 32'h1);
    apb(1'b1, A_CTRL, 32'h3);
    rchk("running", A_CTRL, 32'h3);
    apb(1'b1, A_CTRL, 32'h0);
    rchk("aborted", A_CTRL, 32'h0);
    chk("req off", {30'h0, sample_req, converter_reset_n}, 32'h0);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    lat = 8'd3;
    val_pos = 10'h2A5;
    val_neg = 10'h15A;
    fail_count = 0;
    tests_run = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_static();
    t_route();
    t_disabled();
    t_convert();
    t_chop();
    t_abort();
    end_of_test();
  end
endmodule

`default_nettype wire
